// >>> hw/dcf_params.svh
// constants for the dual-port fifo with port flags
// assumes inclusion by bare name from the package and the top module
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

// ----------------------------------------------------------------------
// storage shape
// ----------------------------------------------------------------------
`define DCF_WORDS        10'h200
`define DCF_ADDR_W       9
`define DCF_DATA_W       36
`define DCF_STAGE_DEPTH  32

// ----------------------------------------------------------------------
// offset limits for the near flags
// ----------------------------------------------------------------------
`define DCF_OFS_MIN      9'h001
`define DCF_OFS_MAX      9'h1fc

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DCF_OV_RST       1'b0
`define DCF_NE_RST       1'b0
`define DCF_IS_RST       1'b0
`define DCF_NF_RST       1'b1
`define DCF_MAIL_RST     1'b1
`define DCF_PTR_RST      10'h000
`define DCF_WORD_RST     36'h0_0000_0000

`endif

// >>> hw/dcf_pkg.sv
// types shared by the dual-port fifo design
// assumes the constants header sits beside this file
`include "dcf_params.svh"

package dcf_pkg;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef logic [`DCF_DATA_W-1:0] dcf_word_t;
    typedef logic [9:0]             dcf_ptr_t;
    typedef logic [8:0]             dcf_ofs_t;

    // port control group, all levels sampled on sys_clk
    typedef struct packed {
        logic select_n;
        logic dir;
        logic gate;
        logic mail_sel;
    } dcf_ctl_s;

    // output register state, one-hot
    typedef enum logic [1:0] {
        DCF_OR_EMPTY = 2'h1,
        DCF_OR_VALID = 2'h2
    } dcf_or_e;

endpackage

// >>> hw/dcf_top.sv
// dual-port 512 x 36 fifo with mailboxes and port flags
// assumes port clocks and all inputs are synchronous to sys_clk
//
// Contract
// - port a shows mail2; mail2 read sets flag
// - port b drives only when selected, dir high
// - fifo read needs select, dir, gate, valid flag
// - reads and writes run independently
// - port b shows mail1 or output register
// - gate low means no port operation
// - empty output register loads automatically
// - near and space flags have two port clock stages, valid three
// - flag levels follow stored word count
// - output register word counts as read
// - reads with valid flag low do nothing
// - pointers advance once per transfer
// - first word appears on third b edge
// - write seen by b edges after it
// - writes ignored while input space low
// - input space rises second a edge after read
// - read seen by a edges after it
// - near empty high above low offset
// - near empty rises second b edge
// - near full low from 512 minus offset
// - near full rises second a edge
// - fifo write needs select, dir, gate, space
// - offsets clamped to 1 through 508
// - mailbox write clears flag, blocks more
`timescale 1ns/1ps
`include "dcf_params.svh"

// ----------------------------------------------------------------------
// staging fifo
// ----------------------------------------------------------------------
module dcf_stage_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 32
) (
    // clock and control
    input  logic             sys_clk,
    input  logic             rst,
    input  logic             ce,
    // fill side
    input  logic             in_valid,
    output logic             in_ready,
    input  logic [WIDTH-1:0] in_data,
    // drain side
    output logic             out_valid,
    input  logic             out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    wire              push;
    wire              pop;

    // handshake decode
    assign in_ready  = cnt_reg != FULL;
    assign out_valid = cnt_reg != '0;
    assign out_data  = store[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // entry storage
    always_ff @(posedge sys_clk) begin
        if (ce && push) begin
            store[wr_reg] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (ce) begin
            wr_reg  <= wr_reg + AW'(push);
            rd_reg  <= rd_reg + AW'(pop);
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------------
// top: fifo, mailboxes, flags
// ----------------------------------------------------------------------
module dcf_top (
    // system
    input  logic                sys_clk,
    input  logic                rst,
    input  logic                ce,
    // port a
    input  logic                port_a_clock,
    input  dcf_pkg::dcf_ctl_s   port_a_ctl,
    input  dcf_pkg::dcf_word_t  port_a_din,
    output dcf_pkg::dcf_word_t  port_a_dout,
    output logic                port_a_oe_n,
    // port b
    input  logic                port_b_clock,
    input  dcf_pkg::dcf_ctl_s   port_b_ctl,
    input  dcf_pkg::dcf_word_t  port_b_din,
    output dcf_pkg::dcf_word_t  port_b_dout,
    output logic                port_b_oe_n,
    // flag offsets
    input  dcf_pkg::dcf_ofs_t   low_water_offset,
    input  dcf_pkg::dcf_ofs_t   high_water_offset,
    // flags
    output logic                output_valid_flag,
    output logic                near_empty_flag,
    output logic                input_space_flag,
    output logic                near_full_flag,
    output logic                mail_ab_flag,
    output logic                mail_ba_flag
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    dcf_pkg::dcf_word_t store [`DCF_WORDS];
    dcf_pkg::dcf_word_t out_word_reg;
    dcf_pkg::dcf_word_t mail1_reg;
    dcf_pkg::dcf_word_t mail2_reg;
    dcf_pkg::dcf_word_t a_dout_reg;
    dcf_pkg::dcf_word_t b_dout_reg;
    dcf_pkg::dcf_ptr_t  wptr_reg;
    dcf_pkg::dcf_ptr_t  rptr_reg;
    dcf_pkg::dcf_ptr_t  wa_ptr_reg;
    dcf_pkg::dcf_ptr_t  wp_seen_reg;
    dcf_pkg::dcf_ptr_t  wp_used_reg;
    dcf_pkg::dcf_ptr_t  rp_seen_reg;
    dcf_pkg::dcf_or_e   or_state_reg;
    dcf_pkg::dcf_or_e   or_state_next;
    logic               a_clk_q_reg;
    logic               b_clk_q_reg;
    logic               ov_reg;
    logic               ne_reg;
    logic               is_reg;
    logic               nf_reg;
    logic               mab_reg;
    logic               mba_reg;
    logic               a_oe_n_reg;
    logic               b_oe_n_reg;
    logic               load;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    wire                a_edge;
    wire                b_edge;
    wire                a_go;
    wire                b_go;
    wire                a_fifo_wr;
    wire                a_mail1_wr;
    wire                a_mail2_rd;
    wire                b_fifo_rd;
    wire                b_mail1_rd;
    wire                b_mail2_wr;
    wire                stg_in_ready;
    wire                stg_out_valid;
    wire                drain;
    wire                mem_room;
    dcf_pkg::dcf_word_t stg_out_data;
    dcf_pkg::dcf_ofs_t  lo_ofs;
    dcf_pkg::dcf_ofs_t  hi_ofs;
    dcf_pkg::dcf_ptr_t  rptr_next;
    dcf_pkg::dcf_ptr_t  wa_next;
    dcf_pkg::dcf_ptr_t  cnt_a;
    dcf_pkg::dcf_ptr_t  cnt_b;
    dcf_pkg::dcf_ptr_t  cnt_ne;
    dcf_pkg::dcf_ptr_t  nf_limit;
    wire                has_word;

    // port clock rising edges seen on sys_clk
    assign a_edge = port_a_clock && !a_clk_q_reg;
    assign b_edge = port_b_clock && !b_clk_q_reg;

    // operations happen only with gate high
    assign a_go = a_edge && !port_a_ctl.select_n && port_a_ctl.gate;
    assign b_go = b_edge && !port_b_ctl.select_n && port_b_ctl.gate;

    // port a functions
    assign a_fifo_wr  = a_go && port_a_ctl.dir && !port_a_ctl.mail_sel
                        && is_reg && stg_in_ready;
    assign a_mail1_wr = a_go && port_a_ctl.dir && port_a_ctl.mail_sel
                        && mab_reg;
    assign a_mail2_rd = a_go && !port_a_ctl.dir && port_a_ctl.mail_sel;

    // port b functions, dir polarity inverted
    assign b_fifo_rd  = b_go && port_b_ctl.dir && !port_b_ctl.mail_sel;
    assign b_mail1_rd = b_go && port_b_ctl.dir && port_b_ctl.mail_sel;
    assign b_mail2_wr = b_go && !port_b_ctl.dir && port_b_ctl.mail_sel
                        && mba_reg;

    // offsets held inside the legal span
    assign lo_ofs = (low_water_offset < `DCF_OFS_MIN)  ? `DCF_OFS_MIN :
                    (low_water_offset > `DCF_OFS_MAX)  ? `DCF_OFS_MAX :
                    low_water_offset;
    assign hi_ofs = (high_water_offset < `DCF_OFS_MIN) ? `DCF_OFS_MIN :
                    (high_water_offset > `DCF_OFS_MAX) ? `DCF_OFS_MAX :
                    high_water_offset;

    // staging drains into the store while it has room
    assign mem_room = (wptr_reg - rptr_reg) != `DCF_WORDS;
    assign drain    = stg_out_valid && mem_room;

    // ------------------------------------------------------------------
    // write staging
    // ------------------------------------------------------------------
    dcf_stage_fifo #(
        .WIDTH (`DCF_DATA_W),
        .DEPTH (`DCF_STAGE_DEPTH)
    ) u_stage (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (a_fifo_wr),
        .in_ready  (stg_in_ready),
        .in_data   (port_a_din),
        .out_valid (stg_out_valid),
        .out_ready (mem_room),
        .out_data  (stg_out_data)
    );

    // ------------------------------------------------------------------
    // port b side counts; output register word already read
    // ------------------------------------------------------------------
    assign cnt_b     = wp_used_reg - rptr_reg;
    assign has_word  = cnt_b != '0;
    assign rptr_next = rptr_reg + 10'(load);
    assign cnt_ne    = wp_seen_reg - rptr_next;

    // ------------------------------------------------------------------
    // port a side counts, staged words included
    // ------------------------------------------------------------------
    assign wa_next  = wa_ptr_reg + 10'(a_fifo_wr);
    assign cnt_a    = wa_next - rp_seen_reg;
    assign nf_limit = `DCF_WORDS - {1'b0, hi_ofs};

    // output register control
    always_comb begin
        or_state_next = or_state_reg;
        load          = 1'b0;
        case (or_state_reg)
            dcf_pkg::DCF_OR_EMPTY: begin
                // next word loads on the edge that raises the flag
                if (b_edge && has_word) begin
                    load          = 1'b1;
                    or_state_next = dcf_pkg::DCF_OR_VALID;
                end
            end
            dcf_pkg::DCF_OR_VALID: begin
                // selected read shifts the next word or empties
                if (b_fifo_rd && has_word) begin
                    load = 1'b1;
                end else if (b_fifo_rd) begin
                    or_state_next = dcf_pkg::DCF_OR_EMPTY;
                end
            end
            default: begin
                or_state_next = dcf_pkg::DCF_OR_EMPTY;
            end
        endcase
    end

    // store write from the staging fifo
    always_ff @(posedge sys_clk) begin
        if (ce && drain) begin
            store[wptr_reg[8:0]] <= stg_out_data;
        end
    end

    // edge detect history
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            a_clk_q_reg <= 1'b0;
            b_clk_q_reg <= 1'b0;
        end else if (ce) begin
            a_clk_q_reg <= port_a_clock;
            b_clk_q_reg <= port_b_clock;
        end
    end

    // write pointers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wa_ptr_reg <= `DCF_PTR_RST;
            wptr_reg   <= `DCF_PTR_RST;
        end else if (ce) begin
            wa_ptr_reg <= wa_next;
            wptr_reg   <= wptr_reg + 10'(drain);
        end
    end

    // port b pipeline: write seen on later b edges only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wp_seen_reg  <= `DCF_PTR_RST;
            wp_used_reg  <= `DCF_PTR_RST;
            rptr_reg     <= `DCF_PTR_RST;
            or_state_reg <= dcf_pkg::DCF_OR_EMPTY;
            ov_reg       <= `DCF_OV_RST;
            ne_reg       <= `DCF_NE_RST;
            out_word_reg <= `DCF_WORD_RST;
        end else if (ce) begin
            if (b_edge) begin
                wp_seen_reg <= wptr_reg;
                wp_used_reg <= wp_seen_reg;
                ne_reg      <= cnt_ne > {1'b0, lo_ofs};
            end
            if (load) begin
                out_word_reg <= store[rptr_reg[8:0]];
            end
            rptr_reg     <= rptr_next;
            or_state_reg <= or_state_next;
            ov_reg       <= or_state_next == dcf_pkg::DCF_OR_VALID;
        end
    end

    // port a pipeline: read seen on later a edges only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rp_seen_reg <= `DCF_PTR_RST;
            is_reg      <= `DCF_IS_RST;
            nf_reg      <= `DCF_NF_RST;
        end else if (ce && a_edge) begin
            rp_seen_reg <= rptr_reg;
            is_reg      <= cnt_a != `DCF_WORDS;
            nf_reg      <= cnt_a < nf_limit;
        end
    end

    // mailboxes, a write beats a same-cycle read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mail1_reg <= `DCF_WORD_RST;
            mail2_reg <= `DCF_WORD_RST;
            mab_reg   <= `DCF_MAIL_RST;
            mba_reg   <= `DCF_MAIL_RST;
        end else if (ce) begin
            if (a_mail1_wr) begin
                mail1_reg <= port_a_din;
                mab_reg   <= 1'b0;
            end else if (b_mail1_rd) begin
                mab_reg   <= 1'b1;
            end
            if (b_mail2_wr) begin
                mail2_reg <= port_b_din;
                mba_reg   <= 1'b0;
            end else if (a_mail2_rd) begin
                mba_reg   <= 1'b1;
            end
        end
    end

    // data output registers and drive enables
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            a_dout_reg <= `DCF_WORD_RST;
            b_dout_reg <= `DCF_WORD_RST;
            a_oe_n_reg <= 1'b1;
            b_oe_n_reg <= 1'b1;
        end else if (ce) begin
            a_dout_reg <= mail2_reg;
            a_oe_n_reg <= port_a_ctl.select_n || port_a_ctl.dir;
            b_dout_reg <= port_b_ctl.mail_sel ? mail1_reg
                                              : out_word_reg;
            b_oe_n_reg <= port_b_ctl.select_n || !port_b_ctl.dir;
        end
    end

    // outputs straight from flops
    assign port_a_dout       = a_dout_reg;
    assign port_a_oe_n       = a_oe_n_reg;
    assign port_b_dout       = b_dout_reg;
    assign port_b_oe_n       = b_oe_n_reg;
    assign output_valid_flag = ov_reg;
    assign near_empty_flag   = ne_reg;
    assign input_space_flag  = is_reg;
    assign near_full_flag    = nf_reg;
    assign mail_ab_flag      = mab_reg;
    assign mail_ba_flag      = mba_reg;
endmodule

// >>> test/dcf_top_props.sv
// assertions on the dual-port fifo top ports
// assumes one sys_clk domain with ce held high by the bench
`timescale 1ns/1ps
module dcf_top_props (
    // system
    input logic              sys_clk,
    input logic              rst,
    input logic              ce,
    // port a
    input logic              port_a_clock,
    input dcf_pkg::dcf_ctl_s port_a_ctl,
    input logic              port_a_oe_n,
    // port b
    input logic              port_b_clock,
    input dcf_pkg::dcf_ctl_s port_b_ctl,
    input logic              port_b_oe_n,
    // flags
    input logic              output_valid_flag,
    input logic              near_empty_flag,
    input logic              input_space_flag,
    input logic              near_full_flag,
    input logic              mail_ab_flag,
    input logic              mail_ba_flag
);
    logic a_last;
    logic b_last;
    logic a_rise;
    logic b_rise;
    logic a_m1_wr;
    logic a_m2_rd;
    logic b_m2_wr;
    logic b_m1_rd;

    // port clock history, cleared in reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            a_last <= 1'b0;
            b_last <= 1'b0;
        end else if (ce) begin
            a_last <= port_a_clock;
            b_last <= port_b_clock;
        end
    end

    // edge marks and decoded mailbox operations
    assign a_rise  = port_a_clock & ~a_last & ce;
    assign b_rise  = port_b_clock & ~b_last & ce;
    assign a_m1_wr = a_rise && port_a_ctl == 4'h7;
    assign a_m2_rd = a_rise && port_a_ctl == 4'h3;
    assign b_m2_wr = b_rise && port_b_ctl == 4'h3;
    assign b_m1_rd = b_rise && port_b_ctl == 4'h7;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_a_oe_drive: assert property (
        !port_a_ctl.select_n && !port_a_ctl.dir |=> !port_a_oe_n)
        else $error("port a not driving");
    a_a_oe_float: assert property (
        port_a_ctl.select_n || port_a_ctl.dir |=> port_a_oe_n)
        else $error("port a driving when not read");
    a_b_oe_drive: assert property (
        !port_b_ctl.select_n && port_b_ctl.dir |=> !port_b_oe_n)
        else $error("port b not driving");
    a_b_oe_float: assert property (
        port_b_ctl.select_n || !port_b_ctl.dir |=> port_b_oe_n)
        else $error("port b driving when not read");
    a_mail1_clear: assert property (
        a_m1_wr && mail_ab_flag |=> !mail_ab_flag)
        else $error("mail1 write left flag high");
    a_mail1_set: assert property (
        b_m1_rd && !(a_m1_wr && mail_ab_flag) |=> mail_ab_flag)
        else $error("mail1 read left flag low");
    a_mail1_hold: assert property (
        !a_m1_wr && !b_m1_rd |=> $stable(mail_ab_flag))
        else $error("mail1 flag moved without cause");
    a_mail2_clear: assert property (
        b_m2_wr && mail_ba_flag |=> !mail_ba_flag)
        else $error("mail2 write left flag high");
    a_mail2_set: assert property (
        a_m2_rd && !(b_m2_wr && mail_ba_flag) |=> mail_ba_flag)
        else $error("mail2 read left flag low");
    a_valid_b_edge: assert property (
        $changed(output_valid_flag) |-> $past(b_rise))
        else $error("output valid moved off a b edge");
    a_empty_b_edge: assert property (
        $changed(near_empty_flag) |-> $past(b_rise))
        else $error("near empty moved off a b edge");
    a_space_a_edge: assert property (
        $changed(input_space_flag) |-> $past(a_rise))
        else $error("input space moved off an a edge");
    a_full_a_edge: assert property (
        $changed(near_full_flag) |-> $past(a_rise))
        else $error("near full moved off an a edge");
    a_full_near: assert property (
        $fell(input_space_flag) |-> !near_full_flag)
        else $error("full while near full high");

    c_full:  cover property ($fell(input_space_flag));
    c_mail1: cover property (b_m1_rd && !mail_ab_flag);
    c_drain: cover property ($fell(output_valid_flag));
endmodule

// >>> test/dcf_port_clk_model.sv
// port clock model for the two bus masters of the fifo
// assumes sys_clk from the bench; clocks move on its falling edge
`timescale 1ns/1ps
module dcf_port_clk_model (
    // system
    input  logic sys_clk,
    input  logic rst,
    input  logic slow,
    // port clocks and upcoming edge marks
    output logic port_a_clock,
    output logic port_b_clock,
    output logic a_rise,
    output logic b_rise
);
    logic [2:0] a_cnt = 3'h0;
    logic [2:0] b_cnt = 3'h0;
    logic       a_last;
    logic       b_last;

    // free running, unrelated rates: a every 2, b every 3 or 6
    always @(negedge sys_clk) begin
        a_cnt <= (a_cnt >= 3'h1) ? 3'h0 : a_cnt + 3'h1;
        b_cnt <= (b_cnt >= (slow ? 3'h5 : 3'h2)) ? 3'h0 : b_cnt + 3'h1;
    end
    assign port_a_clock = (a_cnt == 3'h0);
    assign port_b_clock = (b_cnt == 3'h0);

    // edge history as the block sees it, cleared in reset
    always @(posedge sys_clk) begin
        a_last <= rst ? 1'b0 : port_a_clock;
        b_last <= rst ? 1'b0 : port_b_clock;
    end
    assign a_rise = port_a_clock & ~a_last & ~rst;
    assign b_rise = port_b_clock & ~b_last & ~rst;
endmodule

// >>> test/dcf_top_tb_top.sv
// self-checking bench for the dual-port fifo with port flags
// assumes the design, its package and the port clock model
`timescale 1ns/1ps
module dcf_top_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic               sys_clk;
    logic               rst;
    logic               ce;
    logic               slow;
    logic               port_a_clock;
    logic               port_b_clock;
    logic               a_rise;
    logic               b_rise;
    dcf_pkg::dcf_ctl_s  port_a_ctl;
    dcf_pkg::dcf_ctl_s  port_b_ctl;
    dcf_pkg::dcf_word_t port_a_din;
    dcf_pkg::dcf_word_t port_b_din;
    dcf_pkg::dcf_word_t port_a_dout;
    dcf_pkg::dcf_word_t port_b_dout;
    logic               port_a_oe_n;
    logic               port_b_oe_n;
    dcf_pkg::dcf_ofs_t  low_water_offset;
    dcf_pkg::dcf_ofs_t  high_water_offset;
    logic               output_valid_flag;
    logic               near_empty_flag;
    logic               input_space_flag;
    logic               near_full_flag;
    logic               mail_ab_flag;
    logic               mail_ba_flag;
    dcf_pkg::dcf_word_t exp_q[$];
    int                 miscompares = 0;
    int                 checks = 0;
    int                 cyc = 0;
    int                 x_ofs;
    int                 i;

    dcf_top dut (.sys_clk, .rst, .ce, .port_a_clock, .port_a_ctl,
        .port_a_din, .port_a_dout, .port_a_oe_n, .port_b_clock,
        .port_b_ctl, .port_b_din, .port_b_dout, .port_b_oe_n,
        .low_water_offset, .high_water_offset, .output_valid_flag,
        .near_empty_flag, .input_space_flag, .near_full_flag,
        .mail_ab_flag, .mail_ba_flag);

    dcf_port_clk_model u_clk (.sys_clk, .rst, .slow, .port_a_clock,
        .port_b_clock, .a_rise, .b_rise);

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input dcf_pkg::dcf_word_t got,
                       input dcf_pkg::dcf_word_t exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one port operation held until that port's edge is taken
    task automatic op(input bit pb, input logic [3:0] c,
                      input dcf_pkg::dcf_word_t d);
        int n;
        @(negedge sys_clk);
        if (pb) begin
            port_b_ctl = c;
            port_b_din = d;
        end else begin
            port_a_ctl = c;
            port_a_din = d;
        end
        n = 0;
        #1;
        while (!(pb ? b_rise : a_rise) && n < 20) begin
            @(negedge sys_clk);
            #1;
            n++;
        end
        @(negedge sys_clk);
        if (pb) begin
            port_b_ctl = c & 4'hd;
            port_b_din = ~d;
        end else begin
            port_a_ctl = c & 4'hd;
            port_a_din = ~d;
        end
    endtask

    task automatic fifo_wr(input bit push);
        dcf_pkg::dcf_word_t d;
        d = {4'($urandom), $urandom};
        if (push) exp_q.push_back(d);
        op(1'b0, 4'h6, d);
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, read monitor
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            $display("BAD %0t run hung", $time);
            finish_test();
        end
    end

    // each taken fifo read shows the oldest unread word
    always @(posedge sys_clk) begin
        if (b_rise && port_b_ctl == 4'h6 && output_valid_flag === 1'b1) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("BAD %0t word with none written", $time);
            end else begin
                chk(port_b_dout, exp_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32760));
        rst = 1'b1;
        ce = 1'b1;
        slow = 1'b0;
        port_a_ctl = 4'h8;
        port_b_ctl = 4'h4;
        port_a_din = 36'h0;
        port_b_din = 36'h0;
        x_ofs = 1 + $urandom % 8;
        low_water_offset = 9'(x_ofs);
        high_water_offset = 9'(1 + $urandom % 8);
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk(36'({output_valid_flag, near_empty_flag, input_space_flag,
            near_full_flag, mail_ab_flag, mail_ba_flag}), 36'h0f);
        // mail2: write, ignored second write, shown and read on port a
        op(1'b1, 4'h3, 36'h1_2345_6789);
        op(1'b1, 4'h3, 36'h0_dead_beef);
        op(1'b0, 4'h1, 36'h0);
        chk(36'({mail_ba_flag, port_a_oe_n}), 36'h0);
        chk(port_a_dout, 36'h1_2345_6789);
        op(1'b0, 4'h3, 36'h0);
        chk(36'(mail_ba_flag), 36'h1);
        // mail1: write, ignored second write, shown and read on port b
        op(1'b0, 4'h7, 36'h0_a5a5_5a5a);
        op(1'b0, 4'h7, 36'h0_ffff_0000);
        op(1'b1, 4'h5, 36'h0);
        chk(port_b_dout, 36'h0_a5a5_5a5a);
        chk(36'(mail_ab_flag), 36'h0);
        op(1'b1, 4'h7, 36'h0);
        op(1'b1, 4'h4, 36'h0);
        chk(36'(mail_ab_flag), 36'h1);
        // read of an empty fifo does nothing
        op(1'b1, 4'h6, 36'h0);
        chk(36'(output_valid_flag), 36'h0);
        // fill, checking near empty around its offset
        for (i = 0; i < 512; i++) begin
            fifo_wr(1'b1);
            if (i == x_ofs || i == x_ofs + 1) begin
                repeat (20) @(negedge sys_clk);
                chk(36'({output_valid_flag, near_empty_flag}),
                    (i == x_ofs) ? 36'h2 : 36'h3);
            end
        end
        repeat (20) @(negedge sys_clk);
        chk(36'({input_space_flag, near_full_flag}), 36'h2);
        fifo_wr(1'b1);
        repeat (20) @(negedge sys_clk);
        chk(36'({input_space_flag, near_full_flag}), 36'h0);
        fifo_wr(1'b0);
        op(1'b1, 4'h6, 36'h0);
        repeat (20) @(negedge sys_clk);
        chk(36'(input_space_flag), 36'h1);
        // drain, reader slow for the first part
        slow = 1'b1;
        for (i = 0; i < 600; i++) begin
            if (i == 256) slow = 1'b0;
            if (output_valid_flag) op(1'b1, 4'h6, 36'h0);
        end
        repeat (20) @(negedge sys_clk);
        chk(36'(exp_q.size()), 36'h0);
        chk(36'({output_valid_flag, near_empty_flag, input_space_flag,
            near_full_flag}), 36'h3);
        finish_test();
    end
endmodule

bind dcf_top dcf_top_props u_props (.sys_clk, .rst, .ce, .port_a_clock,
    .port_a_ctl, .port_a_oe_n, .port_b_clock, .port_b_ctl, .port_b_oe_n,
    .output_valid_flag, .near_empty_flag, .input_space_flag,
    .near_full_flag, .mail_ab_flag, .mail_ba_flag);
